/* File: core/sdr_map.vh */
/*
 register offsets, field positions, reset values and field codes of the
 supply-drop and rate control register bank. assumes inclusion by bare name.
*/
`ifndef SDR_MAP_VH
`define SDR_MAP_VH

`define SDR_OFF_DROP_CTRL     8'h04
`define SDR_OFF_DROP_THR      8'h05
`define SDR_OFF_PAGE_WRAP     8'h0f
`define SDR_OFF_FRAME_RATE    8'h28
`define SDR_OFF_CLOCK_CHECK   8'h29

`define SDR_RST_DROP_CTRL     8'h00
`define SDR_RST_DROP_THR      8'h44
`define SDR_RST_PAGE_WRAP     8'h00
`define SDR_RST_FRAME_RATE    8'h00
`define SDR_RST_CLOCK_CHECK   8'h00

`define SDR_BIT_DROP_ON       0
`define SDR_BIT_AVG_LO        1
`define SDR_BIT_AVG_HI        2
`define SDR_BIT_HIZ_SEL       3
`define SDR_BIT_WRAP_DIS      3
`define SDR_BIT_RATE_LO       0
`define SDR_BIT_RATE_HI       3
`define SDR_BIT_RATIO_LO      4
`define SDR_BIT_RATIO_HI      7

`define SDR_AVG_1             2'h0
`define SDR_AVG_16            2'h1
`define SDR_AVG_32            2'h2
`define SDR_AVG_64            2'h3

`define SDR_RATIO_32          4'h3
`define SDR_RATIO_64          4'h5
`define SDR_RATIO_128         4'h7
`define SDR_RATIO_256         4'h9
`define SDR_RATIO_512         4'hb

`define SDR_RATE_AUTO         4'h0
`define SDR_RATE_32K          4'h6
`define SDR_RATE_44K1         4'h8
`define SDR_RATE_48K          4'h9
`define SDR_RATE_96K          4'hb
`define SDR_RATE_192K         4'hd

`define SDR_STATE_DEEP_SLEEP  2'h0
`define SDR_STATE_SLEEP       2'h1
`define SDR_STATE_HIZ         2'h2
`define SDR_STATE_PLAY        2'h3

`define SDR_PAGE_LAST         8'h7f
`define SDR_PAGE_WRAP_START   8'h08
`define SDR_PAGE_FIRST        8'h00

`endif

/* File: core/sdr_regs.v */
/*
 supply-drop detection and rate control register bank: register file written
 by the control-port engine, drop averaging/compare, auto-increment address
 step, frame ratio capture and sample-rate decode.
 assumes the control-port engine gives a one-cycle write or read strobe with
 an 8-bit offset, and that sense samples and frame ratios arrive as strobed
 words synchronous to CLK.
*/
`include "sdr_map.vh"
`timescale 1ns/1ps
`default_nettype none

module sdr_regs (
   input  wire       CLK,
   input  wire       RESETN,
   input  wire       WR_STB,
   input  wire       RD_STB,
   input  wire [7:0] REG_ADDR,
   input  wire [7:0] WR_DATA,
   input  wire [7:0] BOOK,
   input  wire [7:0] PAGE,
   input  wire [1:0] STATE_REQ,
   input  wire       SENSE_VLD,
   input  wire [7:0] SENSE_CODE,
   input  wire       RATIO_VLD,
   input  wire [9:0] BCLK_COUNT,
   output reg  [7:0] RD_DATA,
   output reg        RD_VLD,
   output reg  [7:0] NEXT_ADDR,
   output reg  [7:0] NEXT_PAGE,
   output reg        DROP_FLAG,
   output reg  [1:0] DEV_STATE,
   output reg  [3:0] RATE_MODE,
   output reg        RATE_AUTO,
   output reg        RATE_BAD
);

   reg  [7:0]  drop_ctrl_q;
   reg  [7:0]  drop_thr_q;
   reg  [7:0]  page_wrap_q;
   reg  [7:0]  frame_rate_q;
   reg  [7:0]  clock_check_q;
   reg  [13:0] acc_q;
   reg  [6:0]  cnt_q;
   reg  [13:0] acc_d;
   reg  [7:0]  avg;
   reg  [6:0]  win_len;
   reg  [3:0]  ratio_code;
   reg         ratio_ok;
   reg         rate_ok;
   wire        drop_check_on;
   wire [1:0]  drop_avg_count;
   wire        drop_hiz_select;
   wire        page_wrap_disable;
   wire [3:0]  rate_select;
   wire        win_done;

   assign drop_check_on     = drop_ctrl_q[`SDR_BIT_DROP_ON];
   assign drop_avg_count    = drop_ctrl_q[`SDR_BIT_AVG_HI:`SDR_BIT_AVG_LO];
   assign drop_hiz_select   = drop_ctrl_q[`SDR_BIT_HIZ_SEL];
   assign page_wrap_disable = page_wrap_q[`SDR_BIT_WRAP_DIS];
   assign rate_select       = frame_rate_q[`SDR_BIT_RATE_HI:`SDR_BIT_RATE_LO];

   // window length in samples; the sum is divided by shifting
   always @* begin
      case (drop_avg_count)
         `SDR_AVG_16: win_len = 7'd16;
         `SDR_AVG_32: win_len = 7'd32;
         `SDR_AVG_64: win_len = 7'd64;
         default:     win_len = 7'd1;
      endcase
   end

   assign win_done = SENSE_VLD && (cnt_q + 7'd1 == win_len);

   always @* begin
      acc_d = acc_q + {6'h00, SENSE_CODE};
      case (drop_avg_count)
         `SDR_AVG_16: avg = acc_d[11:4];
         `SDR_AVG_32: avg = acc_d[12:5];
         `SDR_AVG_64: avg = acc_d[13:6];
         default:     avg = acc_d[7:0];
      endcase
   end

   // bit-clock count per frame to ratio code; unknown ratios leave field alone
   always @* begin
      ratio_ok = 1'b1;
      case (BCLK_COUNT)
         10'd32:  ratio_code = `SDR_RATIO_32;
         10'd64:  ratio_code = `SDR_RATIO_64;
         10'd128: ratio_code = `SDR_RATIO_128;
         10'd256: ratio_code = `SDR_RATIO_256;
         10'd512: ratio_code = `SDR_RATIO_512;
         default: begin
            ratio_code = 4'h0;
            ratio_ok   = 1'b0;
         end
      endcase
   end

   always @* begin
      case (rate_select)
         `SDR_RATE_AUTO, `SDR_RATE_32K, `SDR_RATE_44K1,
         `SDR_RATE_48K, `SDR_RATE_96K, `SDR_RATE_192K: rate_ok = 1'b1;
         default: rate_ok = 1'b0;
      endcase
   end

   // register file; reserved bits are plain storage
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         drop_ctrl_q   <= `SDR_RST_DROP_CTRL;
         drop_thr_q    <= `SDR_RST_DROP_THR;
         page_wrap_q   <= `SDR_RST_PAGE_WRAP;
         frame_rate_q  <= `SDR_RST_FRAME_RATE;
         clock_check_q <= `SDR_RST_CLOCK_CHECK;
      end else begin
         if (WR_STB) begin
            case (REG_ADDR)
               `SDR_OFF_DROP_CTRL:   drop_ctrl_q   <= WR_DATA;
               `SDR_OFF_DROP_THR:    drop_thr_q    <= WR_DATA;
               `SDR_OFF_PAGE_WRAP:   page_wrap_q   <= WR_DATA;
               `SDR_OFF_FRAME_RATE:  frame_rate_q[3:0] <= WR_DATA[3:0];
               `SDR_OFF_CLOCK_CHECK: clock_check_q <= WR_DATA;
               default: ;
            endcase
         end
         // measured ratio wins over a host write to the same field
         if (RATIO_VLD && ratio_ok)
            frame_rate_q[`SDR_BIT_RATIO_HI:`SDR_BIT_RATIO_LO] <= ratio_code;
         else if (WR_STB && REG_ADDR == `SDR_OFF_FRAME_RATE)
            frame_rate_q[7:4] <= WR_DATA[7:4];
      end
   end

   // read port: one cycle after the strobe; unmapped offsets read zero
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RD_DATA <= 8'h00;
         RD_VLD  <= 1'b0;
      end else begin
         RD_VLD <= RD_STB;
         if (RD_STB) begin
            case (REG_ADDR)
               `SDR_OFF_DROP_CTRL:   RD_DATA <= drop_ctrl_q;
               `SDR_OFF_DROP_THR:    RD_DATA <= drop_thr_q;
               `SDR_OFF_PAGE_WRAP:   RD_DATA <= page_wrap_q;
               `SDR_OFF_FRAME_RATE:  RD_DATA <= frame_rate_q;
               `SDR_OFF_CLOCK_CHECK: RD_DATA <= clock_check_q;
               default:              RD_DATA <= 8'h00;
            endcase
         end
      end
   end

   // averaging and compare; threshold code is compared directly because
   // sense codes share its linear scale of 30 V over 0xff
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_q     <= 14'h0000;
         cnt_q     <= 7'h00;
         DROP_FLAG <= 1'b0;
      end else if (!drop_check_on) begin
         acc_q     <= 14'h0000;
         cnt_q     <= 7'h00;
         DROP_FLAG <= 1'b0;
      end else if (win_done) begin
         acc_q     <= 14'h0000;
         cnt_q     <= 7'h00;
         DROP_FLAG <= (avg < drop_thr_q);
      end else if (SENSE_VLD) begin
         acc_q <= acc_d;
         cnt_q <= cnt_q + 7'd1;
      end
   end

   // effective device state
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         DEV_STATE <= `SDR_STATE_DEEP_SLEEP;
      end else if (DROP_FLAG && drop_hiz_select && STATE_REQ == `SDR_STATE_PLAY) begin
         DEV_STATE <= `SDR_STATE_HIZ;
      end else begin
         DEV_STATE <= STATE_REQ;
      end
   end

   // rate decode; the host is relied on to pick 44.1 kHz family modes by hand
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         RATE_MODE <= `SDR_RATE_AUTO;
         RATE_AUTO <= 1'b1;
         RATE_BAD  <= 1'b0;
      end else begin
         RATE_MODE <= rate_select;
         RATE_AUTO <= (rate_select == `SDR_RATE_AUTO);
         RATE_BAD  <= !rate_ok;
      end
   end

   // next auto-increment address after REG_ADDR in BOOK/PAGE
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         NEXT_ADDR <= 8'h00;
         NEXT_PAGE <= 8'h00;
      end else if (REG_ADDR != `SDR_PAGE_LAST || BOOK == 8'h00) begin
         NEXT_ADDR <= (REG_ADDR == `SDR_PAGE_LAST) ? `SDR_PAGE_FIRST : REG_ADDR + 8'd1;
         NEXT_PAGE <= PAGE;
      end else if (page_wrap_disable) begin
         NEXT_ADDR <= `SDR_PAGE_FIRST;
         NEXT_PAGE <= PAGE;
      end else begin
         NEXT_ADDR <= `SDR_PAGE_WRAP_START;
         NEXT_PAGE <= PAGE + 8'd1;
      end
   end

endmodule

`default_nettype wire

/* File: testbench/sdr_regs_checker.sv */
/* port checker for the supply-drop and rate register bank.
 assumes it is bound onto sdr_regs, whose port names it shares. */
`timescale 1ns/1ps
`default_nettype none
module sdr_regs_checker (
   input wire       CLK, RESETN, WR_STB, RD_STB, SENSE_VLD, RATIO_VLD,
   input wire [7:0] REG_ADDR, WR_DATA, BOOK, PAGE, SENSE_CODE,
   input wire [7:0] RD_DATA, NEXT_ADDR, NEXT_PAGE,
   input wire [1:0] STATE_REQ, DEV_STATE,
   input wire [9:0] BCLK_COUNT,
   input wire [3:0] RATE_MODE,
   input wire       DROP_FLAG, RD_VLD, RATE_AUTO, RATE_BAD
);
   // shadows of host writes, so no expectation reads design internals
   logic [7:0] ctl_q, thr_q, wrp_q;
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctl_q <= 8'h00;
         thr_q <= 8'h44;
         wrp_q <= 8'h00;
      end else if (WR_STB) begin
         if (REG_ADDR == 8'h04) ctl_q <= WR_DATA;
         if (REG_ADDR == 8'h05) thr_q <= WR_DATA;
         if (REG_ADDR == 8'h0f) wrp_q <= WR_DATA;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence s_ratio512;
      RATIO_VLD && BCLK_COUNT == 10'd512 ##2 RD_STB && REG_ADDR == 8'h28;
   endsequence
   sequence s_lone;
      SENSE_VLD && ctl_q[2:0] == 3'b001;
   endsequence
   AST_RD_ANSWER: assert property (RD_STB |=> RD_VLD)
      else $error("read strobe not answered");
   AST_RATE_AUTO: assert property (RATE_AUTO == (RATE_MODE == 4'h0))
      else $error("auto flag disagrees with rate code");
   AST_RATE_BAD: assert property (RATE_BAD ==
      !(RATE_MODE inside {4'h0, 4'h6, 4'h8, 4'h9, 4'hb, 4'hd}))
      else $error("reserved flag disagrees with rate code");
   AST_DROP_OFF: assert property (WR_STB && REG_ADDR == 8'h04 && !WR_DATA[0]
      |-> ##3 !DROP_FLAG) else $error("drop flag kept while bypassed");
   AST_DROP_HIZ: assert property (DROP_FLAG && STATE_REQ == 2'h3
      |=> DEV_STATE == ($past(ctl_q[3]) ? 2'h2 : 2'h3)) else $error("drop reaction wrong");
   AST_STATE_PASS: assert property (!DROP_FLAG |=> DEV_STATE == $past(STATE_REQ))
      else $error("state request not followed");
   AST_WRAP_NEXT: assert property (REG_ADDR == 8'h7f && BOOK != 8'h00 && !wrp_q[3]
      |=> NEXT_ADDR == 8'h08 && NEXT_PAGE == $past(PAGE) + 8'h01) else $error("no next page");
   AST_WRAP_SAME: assert property (REG_ADDR == 8'h7f && wrp_q[3]
      |=> NEXT_ADDR == 8'h00 && NEXT_PAGE == $past(PAGE)) else $error("no same page wrap");
   AST_ONE_SAMPLE: assert property (s_lone
      |=> DROP_FLAG == ($past(SENSE_CODE) < $past(thr_q))) else $error("single sample compare");
   AST_RATIO_512: assert property (s_ratio512 |=> RD_DATA[7:4] == 4'hb)
      else $error("ratio 512 not captured");
endmodule
bind sdr_regs sdr_regs_checker u_sdr_regs_checker (.*);
`default_nettype wire

/* File: testbench/sdr_host_model.sv */
/* host side of the control port: single-byte write, read and pointer moves.
 assumes one clock; requests launch just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sdr_host_model (
   input  wire logic       CLK,
   input  wire logic [7:0] RD_DATA,
   output logic            WR_STB, RD_STB,
   output logic      [7:0] REG_ADDR, WR_DATA
);
   initial {WR_STB, RD_STB, REG_ADDR, WR_DATA} = 18'h0;
   task automatic wr(input logic [7:0] a, v);
      @(posedge CLK);
      {WR_STB, REG_ADDR, WR_DATA} <= {1'b1, a, v};
      @(posedge CLK);
      {WR_STB, WR_DATA} <= {1'b0, ~v};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge CLK);
      {RD_STB, REG_ADDR} <= {1'b1, a};
      @(posedge CLK);
      RD_STB <= 1'b0;
      #1 v = RD_DATA;
   endtask
   task automatic point(input logic [7:0] a);
      @(posedge CLK);
      REG_ADDR <= a;
   endtask
endmodule
`default_nettype wire

/* File: testbench/sdr_regs_tb_top.sv */
/* self-checking bench for sdr_regs with a host model on the control port.
 assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
module sdr_regs_tb_top;
   logic CLK = 0, RESETN = 0, SENSE_VLD = 0, RATIO_VLD = 0, dr;
   logic WR_STB, RD_STB, RD_VLD, DROP_FLAG, RATE_AUTO, RATE_BAD;
   logic [7:0] REG_ADDR, WR_DATA, RD_DATA, NEXT_ADDR, NEXT_PAGE, d, thr;
   logic [7:0] BOOK = 0, PAGE = 0, SENSE_CODE = 0;
   logic [7:0] adr [6] = '{8'h04, 8'h05, 8'h0f, 8'h28, 8'h29, 8'h06};
   logic [1:0] STATE_REQ = 2'h3, DEV_STATE;
   logic [3:0] RATE_MODE;
   logic [9:0] BCLK_COUNT = 0;
   logic [31:0] seed = 32'h01cb5816;
   int errors = 0, check_count = 0, cyc = 0, k, i, sum;
   always #5 CLK = ~CLK;
   sdr_host_model u_sdr_host_model (.*);
   sdr_regs u_sdr_regs (.*);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic sense(input logic [7:0] c);
      @(posedge CLK);
      {SENSE_VLD, SENSE_CODE} <= {1'b1, c};
      @(posedge CLK);
      {SENSE_VLD, SENSE_CODE} <= {1'b0, ~c};
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(posedge CLK);
      RESETN <= 1'b1;
      // reset image and readback; the last offset is unmapped
      for (k = 0; k < 6; k++) begin
         u_sdr_host_model.rd(adr[k], d);
         chk("reset", adr[k] == 8'h05 ? 8'h44 : 8'h00, d);
         seed = xs(seed);
         u_sdr_host_model.wr(adr[k], seed[7:0] & 8'hf6);
         u_sdr_host_model.rd(adr[k], d);
         chk("readback", k == 5 ? 8'h00 : seed[7:0] & 8'hf6, d);
      end
      for (k = 0; k < 16; k++) begin
         u_sdr_host_model.wr(8'h28, {4'h0, k[3:0]});
         tick(2);
         chk("rate", {4'h0, k[3:0]}, {4'h0, RATE_MODE});
         chk("rate_auto", {7'h0, k == 0}, {7'h0, RATE_AUTO});
         chk("rate_bad", {7'h0, !(k inside {0, 6, 8, 9, 11, 13})}, {7'h0, RATE_BAD});
      end
      for (k = 5; k < 11; k++) begin
         @(posedge CLK);
         {RATIO_VLD, BCLK_COUNT} <= {1'b1, k == 10 ? 10'd100 : 10'(1 << k)};
         @(posedge CLK);
         RATIO_VLD <= 1'b0;
         u_sdr_host_model.rd(8'h28, d);
         chk("ratio", {4'h0, k == 10 ? 4'hb : 4'(2 * k - 7)}, {4'h0, d[7:4]});
      end
      for (k = 0; k < 4; k++) begin
         u_sdr_host_model.wr(8'h04, 8'h00);
         tick(2);
         chk("bypass", 8'h00, {7'h0, DROP_FLAG});
         seed = xs(seed);
         thr = 8'h30 + seed[7:0] % 8'h28;
         u_sdr_host_model.wr(8'h05, thr);
         u_sdr_host_model.wr(8'h04, {4'h0, ~k[0], k[1:0], 1'b1});
         sum = 0;
         for (i = 0; i < (k == 0 ? 1 : 8 << k); i++) begin
            seed = xs(seed);
            d = k == 0 ? thr - 8'h01 : 8'h30 + seed[7:0] % 8'h28;
            sum += d;
            sense(d);
         end
         tick(2);
         dr = (sum >> (k == 0 ? 0 : k + 3)) < thr;
         chk("drop", {7'h0, dr}, {7'h0, DROP_FLAG});
         chk("state", dr && !k[0] ? 8'h02 : 8'h03, {6'h0, DEV_STATE});
      end
      for (k = 0; k < 4; k++) begin
         u_sdr_host_model.wr(8'h0f, k == 1 ? 8'h08 : 8'h00);
         seed = xs(seed);
         @(posedge CLK);
         {BOOK, PAGE, STATE_REQ} <= {k == 2 ? 8'h00 : 8'h01, seed[15:8] & 8'h3f, seed[17:16]};
         u_sdr_host_model.point(k == 3 ? {2'h0, seed[5:0]} : 8'h7f);
         tick(2);
         chk("next_addr", k == 0 ? 8'h08 : k == 3 ? {2'h0, seed[5:0]} + 8'h01 : 8'h00,
             NEXT_ADDR);
         chk("next_page", PAGE + (k == 0 ? 8'h01 : 8'h00), NEXT_PAGE);
      end
      summarize();
   end
endmodule
`default_nettype wire
